// ==== design/fds_pkg.sv ====
package fds_pkg;

	// ------------------------------------------------------------
	// clock and time base
	// ------------------------------------------------------------
	localparam int CLK_HZ        = 40000000;
	localparam int MS_PER_S      = 1000;
	localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;   // cycles per millisecond

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_CFG       = 8'h04;
	localparam logic [7:0] OFS_TARGET    = 8'h08;
	localparam logic [7:0] OFS_FINE_LVL  = 8'h0C;
	localparam logic [7:0] OFS_INFLIGHT  = 8'h10;
	localparam logic [7:0] OFS_INFL_LO   = 8'h14;
	localparam logic [7:0] OFS_INFL_HI   = 8'h18;
	localparam logic [7:0] OFS_EMPTY_MIN = 8'h1C;
	localparam logic [7:0] OFS_EMPTY_MAX = 8'h20;
	localparam logic [7:0] OFS_TOL_HI    = 8'h24;
	localparam logic [7:0] OFS_TOL_LO    = 8'h28;
	localparam logic [7:0] OFS_EMPTY_LVL = 8'h2C;
	localparam logic [7:0] OFS_TIME_A    = 8'h30;
	localparam logic [7:0] OFS_TIME_B    = 8'h34;
	localparam logic [7:0] OFS_TIME_C    = 8'h38;
	localparam logic [7:0] OFS_TIME_D    = 8'h3C;
	localparam logic [7:0] OFS_FLOW_MIN  = 8'h40;
	localparam logic [7:0] OFS_ADJ       = 8'h44;
	localparam logic [7:0] OFS_STATUS    = 8'h48;
	localparam logic [7:0] OFS_RESULT    = 8'h4C;
	localparam logic [7:0] OFS_TARE      = 8'h50;
	localparam logic [7:0] OFS_COUNT     = 8'h54;
	localparam logic [7:0] OFS_TOTAL     = 8'h58;
	localparam logic [7:0] OFS_SUMSQ     = 8'h5C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_START   = 0;
	localparam int CTRL_STOP    = 1;
	localparam int CTRL_SUSPEND = 2;
	localparam int CFG_TARE     = 0;
	localparam int CFG_RELAUNCH = 1;
	localparam int CFG_AUTOINF  = 2;
	localparam int CFG_REFEED   = 3;
	localparam int CFG_EMPTY    = 4;
	localparam int CFG_MODE_LSB = 8;
	localparam int CFG_POL_LSB  = 12;
	localparam int NUM_IN       = 3;   // 0 start, 1 suspend, 2 stop
	localparam int IN_START     = 0;
	localparam int IN_SUSPEND   = 1;
	localparam int IN_STOP      = 2;
	localparam int PCT_DIV      = 100;
	localparam int TOL_BOOST    = 3;

	// ------------------------------------------------------------
	// feed activation orders
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_C_THEN_F   = 3'h0;
	localparam logic [2:0] MODE_CF_START   = 3'h1;
	localparam logic [2:0] MODE_C_ONLY     = 3'h2;
	localparam logic [2:0] MODE_F_C_F      = 3'h3;
	localparam logic [2:0] MODE_F_FC_F     = 3'h4;
	localparam logic [2:0] MODE_H_C_F      = 3'h5;
	localparam logic [2:0] MODE_HCF_START  = 3'h6;
	localparam logic [2:0] MODE_HC_THEN_F  = 3'h7;

	// ------------------------------------------------------------
	// diagnostic codes and reset values
	// ------------------------------------------------------------
	localparam logic [3:0]  DIAG_NONE   = 4'h0;
	localparam logic [3:0]  DIAG_START  = 4'h1;
	localparam logic [3:0]  DIAG_FLOW   = 4'h2;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam logic [7:0]  RST_DEB_MS  = 8'h0A;

	typedef enum logic [3:0] {
		FDS_IDLE      = 4'h0,
		FDS_START_DLY = 4'h1,
		FDS_TARE_WAIT = 4'h2,
		FDS_COARSE_NT = 4'h3,
		FDS_COARSE    = 4'h4,
		FDS_FINE_NT   = 4'h5,
		FDS_FINE      = 4'h6,
		FDS_STAB      = 4'h7,
		FDS_RES_WAIT  = 4'h8,
		FDS_EMPTY     = 4'h9,
		FDS_EMPTY_HLD = 4'hA,
		FDS_END_WAIT  = 4'hB,
		FDS_SUSP      = 4'hC
	} fds_state_t;

endpackage : fds_pkg

// ==== design/fds_sequencer.sv ====
`timescale 1ns/1ps

module fds_sequencer
	import fds_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic signed [31:0]  net_wt,
	input  wire logic signed [31:0]  gross_wt,
	input  wire logic                wt_stable,
	input  wire logic                start_in,
	input  wire logic                suspend_in,
	input  wire logic                stop_in,
	output logic                     high_feed,
	output logic                     coarse_feed,
	output logic                     fine_feed_output,
	output logic                     emptying,
	output logic                     cycle_busy,
	output logic                     result_avail,
	output logic                     out_of_tol,
	output logic                     flow_fail,
	output logic                     dose_fail
);

	typedef struct packed {
		logic [NUM_IN-1:0]      s1, s2, deb, act;
		logic [NUM_IN-1:0][7:0] dcnt;
		logic [15:0]            msdiv;
		logic                   tick;
		fds_state_t             st, rsm;
		logic                   susp_v;
		logic [15:0]            tmr, ftmr;
		logic signed [31:0]     fsnap, tare, result, inflight;
		logic [31:0]            cfg, target, fine_lvl, infl_lo, infl_hi, emin, emax;
		logic [31:0]            tol_hi, tol_lo, empty_lvl, t_a, t_b, t_c, t_d, flow_min, adj;
		logic [31:0]            count, total, sumsq, rdata;
		logic [3:0]             diag;
		logic                   hf, cf, ff, em, busy, ravl, oot, flf, dsf;
	} fds_regs_t;

	fds_regs_t q, n;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// reload value of the millisecond timer for a state
	function automatic logic [15:0] tload(fds_state_t s, fds_regs_t r);
		unique case (s)
			FDS_START_DLY: tload = r.t_a[15:0];
			FDS_TARE_WAIT: tload = r.t_a[31:16];
			FDS_RES_WAIT:  tload = r.t_a[31:16];
			FDS_COARSE_NT: tload = r.t_b[15:0];
			FDS_FINE_NT:   tload = r.t_b[31:16];
			FDS_STAB:      tload = r.t_c[15:0];
			FDS_EMPTY_HLD: tload = r.t_c[31:16];
			FDS_END_WAIT:  tload = r.t_d[15:0];
			default:       tload = 16'h0000;
		endcase
	endfunction : tload

	logic [2:0]         mode;
	logic               wr, rd, hit;
	logic signed [31:0] w, diff, corr, newinf;
	logic signed [47:0] prod;
	logic [8:0]         k;
	logic [NUM_IN-1:0]  lvl, edge_ev;
	logic               ev_start, ev_stop, ev_susp, win_ok, fail_now, hi_bad, lo_bad;
	logic               tmr_done, checks_on, flow_bad;
	fds_state_t         feed_dst;

	assign mode     = q.cfg[CFG_MODE_LSB +: 3];
	assign w        = net_wt - q.tare;
	assign wr       = psel & penable & pwrite;
	assign rd       = psel & ~penable & ~pwrite;
	assign tmr_done = (q.tmr == 16'h0000);

	// apb: zero wait, read data latched in the setup cycle
	assign pready  = psel & penable;
	assign pslverr = psel & penable & ~hit;
	assign prdata  = q.rdata;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		n        = q;
		hit      = 1'b1;
		lvl      = '0;
		edge_ev  = '0;
		diff     = '0;
		prod     = '0;
		corr     = '0;
		newinf   = '0;
		k        = '0;
		hi_bad   = 1'b0;
		lo_bad   = 1'b0;
		flow_bad = 1'b0;
		fail_now = 1'b0;

		// millisecond enable
		n.tick  = 1'b0;
		n.msdiv = q.msdiv + 16'h0001;
		if (q.msdiv == 16'(MS_CYCLES - 1)) begin
			n.msdiv = 16'h0000;
			n.tick  = 1'b1;
		end

		// input synchronisers, debounce, polarity and edges
		n.s1 = {stop_in, suspend_in, start_in};
		n.s2 = q.s1;
		for (int i = 0; i < NUM_IN; i++) begin
			if (q.s2[i] == q.deb[i]) begin
				n.dcnt[i] = 8'h00;
			end else if (q.tick) begin
				n.dcnt[i] = q.dcnt[i] + 8'h01;
				if (q.dcnt[i] >= q.adj[15:8]) begin
					n.deb[i]  = q.s2[i];
					n.dcnt[i] = 8'h00;
				end
			end
			lvl[i]     = q.deb[i] ^ q.cfg[CFG_POL_LSB + i];
			edge_ev[i] = lvl[i] & ~q.act[i];
		end
		n.act = lvl;

		// apb read mux and writes
		unique case (paddr)
			OFS_CTRL:      n.rdata = RST_WORD;
			OFS_CFG:       n.rdata = q.cfg;
			OFS_TARGET:    n.rdata = q.target;
			OFS_FINE_LVL:  n.rdata = q.fine_lvl;
			OFS_INFLIGHT:  n.rdata = q.inflight;
			OFS_INFL_LO:   n.rdata = q.infl_lo;
			OFS_INFL_HI:   n.rdata = q.infl_hi;
			OFS_EMPTY_MIN: n.rdata = q.emin;
			OFS_EMPTY_MAX: n.rdata = q.emax;
			OFS_TOL_HI:    n.rdata = q.tol_hi;
			OFS_TOL_LO:    n.rdata = q.tol_lo;
			OFS_EMPTY_LVL: n.rdata = q.empty_lvl;
			OFS_TIME_A:    n.rdata = q.t_a;
			OFS_TIME_B:    n.rdata = q.t_b;
			OFS_TIME_C:    n.rdata = q.t_c;
			OFS_TIME_D:    n.rdata = q.t_d;
			OFS_FLOW_MIN:  n.rdata = q.flow_min;
			OFS_ADJ:       n.rdata = q.adj;
			OFS_STATUS:    n.rdata = {12'h000, q.diag, 2'h0, q.susp_v, q.st,
				q.hf, q.cf, q.ff, q.em, q.busy, q.ravl, q.oot, q.flf, q.dsf};
			OFS_RESULT:    n.rdata = q.result;
			OFS_TARE:      n.rdata = q.tare;
			OFS_COUNT:     n.rdata = q.count;
			OFS_TOTAL:     n.rdata = q.total;
			OFS_SUMSQ:     n.rdata = q.sumsq;
			default: begin
				n.rdata = RST_WORD;
				hit     = 1'b0;
			end
		endcase
		if (!rd) begin
			n.rdata = q.rdata;
		end
		if (wr) begin
			unique case (paddr)
				OFS_CFG:       n.cfg       = pwdata;
				OFS_TARGET:    n.target    = pwdata;
				OFS_FINE_LVL:  n.fine_lvl  = pwdata;
				OFS_INFLIGHT:  n.inflight  = pwdata;
				OFS_INFL_LO:   n.infl_lo   = pwdata;
				OFS_INFL_HI:   n.infl_hi   = pwdata;
				OFS_EMPTY_MIN: n.emin      = pwdata;
				OFS_EMPTY_MAX: n.emax      = pwdata;
				OFS_TOL_HI:    n.tol_hi    = pwdata;
				OFS_TOL_LO:    n.tol_lo    = pwdata;
				OFS_EMPTY_LVL: n.empty_lvl = pwdata;
				OFS_TIME_A:    n.t_a       = pwdata;
				OFS_TIME_B:    n.t_b       = pwdata;
				OFS_TIME_C:    n.t_c       = pwdata;
				OFS_TIME_D:    n.t_d       = pwdata;
				OFS_FLOW_MIN:  n.flow_min  = pwdata;
				OFS_ADJ:       n.adj       = pwdata;
				default:       n.cfg       = q.cfg;
			endcase
		end

		// events from the bus and from the inputs
		ev_start = edge_ev[IN_START] | (wr & (paddr == OFS_CTRL) & pwdata[CTRL_START]);
		ev_stop  = edge_ev[IN_STOP] | (wr & (paddr == OFS_CTRL) & pwdata[CTRL_STOP]);
		ev_susp  = edge_ev[IN_SUSPEND] | (wr & (paddr == OFS_CTRL) & pwdata[CTRL_SUSPEND]);
		win_ok   = ((q.emin == RST_WORD) && (q.emax == RST_WORD)) ||
			(($signed(q.emin) < gross_wt) && (gross_wt < $signed(q.emax)));
		feed_dst = q.susp_v ? q.rsm : FDS_COARSE_NT;

		// millisecond timer
		if (q.tick && !tmr_done) begin
			n.tmr = q.tmr - 16'h0001;
		end

		// flow supervision, only while feeding past neutralization
		checks_on = (q.st == FDS_COARSE) || (q.st == FDS_FINE);
		if (checks_on && (q.t_d[31:16] != 16'h0000)) begin
			if (q.ftmr == 16'h0000) begin
				flow_bad = (w - q.fsnap) < $signed(q.flow_min);
				n.ftmr   = q.t_d[31:16];
				n.fsnap  = w;
			end else if (q.tick) begin
				n.ftmr = q.ftmr - 16'h0001;
			end
		end

		// sequencer
		if (ev_stop && q.busy) begin
			n.st     = FDS_IDLE;
			n.busy   = 1'b0;
			n.susp_v = 1'b0;
		end else if (ev_susp && q.busy && q.st != FDS_SUSP) begin
			if (q.cfg[CFG_RELAUNCH]) begin
				n.st     = FDS_SUSP;
				n.rsm    = q.st;
				n.susp_v = 1'b1;
			end else begin
				n.st   = FDS_IDLE;
				n.busy = 1'b0;
			end
		end else if (flow_bad) begin
			n.flf  = 1'b1;
			n.dsf  = 1'b1;
			n.diag = DIAG_FLOW;
			if (q.cfg[CFG_RELAUNCH]) begin
				n.st     = FDS_SUSP;
				n.rsm    = q.st;
				n.susp_v = 1'b1;
			end else begin
				n.st   = FDS_IDLE;
				n.busy = 1'b0;
			end
		end else begin
			unique case (q.st)
				FDS_IDLE: begin
					if (ev_start) begin
						if (win_ok) begin
							n.st   = FDS_START_DLY;
							n.busy = 1'b1;
							n.ravl = 1'b0;
							n.oot  = 1'b0;
							n.flf  = 1'b0;
							n.dsf  = 1'b0;
							n.diag = DIAG_NONE;
							n.tare = '0;
						end else begin
							n.dsf  = 1'b1;
							n.diag = DIAG_START;
						end
					end
				end
				FDS_SUSP: begin
					if (ev_start) begin
						n.st = q.cfg[CFG_TARE] ? FDS_TARE_WAIT : q.rsm;
					end
				end
				FDS_START_DLY: begin
					if (tmr_done) begin
						n.st = q.cfg[CFG_TARE] ? FDS_TARE_WAIT : FDS_COARSE_NT;
					end
				end
				FDS_TARE_WAIT: begin
					if (wt_stable || tmr_done) begin
						n.tare = net_wt;
						n.st   = feed_dst;
					end
				end
				FDS_COARSE_NT: begin
					if (tmr_done) begin
						n.st = FDS_COARSE;
					end
				end
				FDS_COARSE: begin
					if (mode == MODE_C_ONLY) begin
						if (w >= $signed(q.target) - q.inflight) begin
							n.st = FDS_STAB;
						end
					end else if (w >= $signed(q.target) - $signed(q.fine_lvl)) begin
						n.st = FDS_FINE_NT;
					end
				end
				FDS_FINE_NT: begin
					if (tmr_done) begin
						n.st = FDS_FINE;
					end
				end
				FDS_FINE: begin
					if (w >= $signed(q.target) - q.inflight) begin
						n.st = FDS_STAB;
					end
				end
				FDS_STAB: begin
					if (tmr_done) begin
						n.st = FDS_RES_WAIT;
					end
				end
				FDS_RES_WAIT: begin
					if (wt_stable || tmr_done) begin
						n.result = w;
						diff     = w - $signed(q.target);
						hi_bad   = diff > $signed(q.tol_hi);
						lo_bad   = -diff > $signed(q.tol_lo);
						fail_now = hi_bad | lo_bad;
						n.oot    = fail_now;
						n.dsf    = q.dsf | fail_now;
						n.ravl   = 1'b1;
						// nine bits so that a boosted percentage up to 300 is not cut
						k        = fail_now ? 9'(q.adj[7:0] * TOL_BOOST) : {1'h0, q.adj[7:0]};
						prod     = 48'(diff) * $signed({39'h0, k});
						corr     = 32'(prod / PCT_DIV);
						newinf   = q.inflight + corr;
						if (q.cfg[CFG_AUTOINF] && (((q.infl_lo == RST_WORD) && (q.infl_hi == RST_WORD))
							|| (($signed(q.infl_lo) < newinf) && (newinf < $signed(q.infl_hi))))) begin
							n.inflight = newinf;
						end
						if (lo_bad && q.cfg[CFG_REFEED]) begin
							n.st = FDS_FINE;
						end else begin
							n.st = q.cfg[CFG_EMPTY] ? FDS_EMPTY : FDS_END_WAIT;
						end
					end
				end
				FDS_EMPTY: begin
					if (gross_wt < $signed(q.empty_lvl)) begin
						n.st = FDS_EMPTY_HLD;
					end
				end
				FDS_EMPTY_HLD: begin
					if (tmr_done) begin
						n.st = FDS_END_WAIT;
					end
				end
				FDS_END_WAIT: begin
					if (tmr_done) begin
						n.st     = FDS_IDLE;
						n.busy   = 1'b0;
						n.susp_v = 1'b0;
						n.count  = q.count + 32'h0000_0001;
						n.total  = q.total + q.result;
						n.sumsq  = q.sumsq + 32'(q.result * q.result);
					end
				end
				default: n.st = FDS_IDLE;
			endcase
		end

		// timer and flow window restart on every state change
		if (n.st != q.st) begin
			n.tmr   = tload(n.st, q);
			n.ftmr  = q.t_d[31:16];
			n.fsnap = w;
			if (q.st == FDS_SUSP && n.st == q.rsm) begin
				n.susp_v = 1'b0;
			end
			if (q.st == FDS_TARE_WAIT && q.susp_v) begin
				n.susp_v = 1'b0;
			end
		end

		// feed outputs by activation order
		n.hf = (n.st == FDS_COARSE_NT || n.st == FDS_COARSE) &&
			(mode == MODE_H_C_F || mode == MODE_HCF_START || mode == MODE_HC_THEN_F);
		n.cf = (n.st == FDS_COARSE_NT || n.st == FDS_COARSE);
		n.ff = (n.st == FDS_FINE_NT || n.st == FDS_FINE) ||
			(n.cf && (mode == MODE_CF_START || mode == MODE_F_C_F ||
			mode == MODE_F_FC_F || mode == MODE_HCF_START));
		n.em = (n.st == FDS_EMPTY || n.st == FDS_EMPTY_HLD);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q       <= '0;
			q.st    <= FDS_IDLE;
			q.rsm   <= FDS_IDLE;
			q.adj   <= {16'h0000, RST_DEB_MS, 8'h00};
		end else begin
			q <= n;
		end
	end

	// process outputs
	assign high_feed        = q.hf;
	assign coarse_feed      = q.cf;
	assign fine_feed_output = q.ff;
	assign emptying         = q.em;
	assign cycle_busy       = q.busy;
	assign result_avail     = q.ravl;
	assign out_of_tol       = q.oot;
	assign flow_fail        = q.flf;
	assign dose_fail        = q.dsf;

endmodule : fds_sequencer

// ==== bench/fds_plant.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// plant model: receiver on the scale, filled by feed valves
// ------------------------------------------------------------
module fds_plant (
	input  wire logic               clk,
	input  wire logic               high_feed,
	input  wire logic               coarse_feed,
	input  wire logic               fine_feed_output,
	input  wire logic               emptying,
	input  wire logic               load,
	input  wire logic signed [31:0] load_val,
	input  wire logic               shaky,
	output logic signed [31:0]      gross_wt,
	output logic signed [31:0]      net_wt,
	output logic                    wt_stable
);
	logic [1:0] calm_r;

	// weight follows the open valves, emptying drains to zero
	always_ff @(posedge clk) begin
		calm_r <= {calm_r[0], !(high_feed | coarse_feed | fine_feed_output | emptying)};
		if (load)
			gross_wt <= load_val;
		else if (emptying)
			gross_wt <= (gross_wt > 32'sh4) ? gross_wt - 32'sh4 : 32'sh0;
		else
			gross_wt <= gross_wt + (high_feed ? 32'sh2 : 32'sh0) + (coarse_feed ? 32'sh2 : 32'sh0)
				+ (fine_feed_output ? 32'sh1 : 32'sh0);
	end

	// no tare here, stable two cycles after the last flow
	assign net_wt    = gross_wt;
	assign wt_stable = (&calm_r) & !shaky;
endmodule : fds_plant

// ==== bench/fds_properties.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// bus and sequencing checks on the sequencer ports
// ------------------------------------------------------------
module fds_properties
	import fds_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        high_feed,
	input wire logic        coarse_feed,
	input wire logic        fine_feed_output,
	input wire logic        emptying,
	input wire logic        cycle_busy,
	input wire logic        result_avail,
	input wire logic        out_of_tol,
	input wire logic        flow_fail,
	input wire logic        dose_fail
);
	logic feeding;

	// any feed valve open
	assign feeding = high_feed | coarse_feed | fine_feed_output;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_pready; psel && penable |-> pready; endproperty
	a_pready: assert property (p_pready) else $error("ready missing in access phase");
	property p_unmapped; psel && penable && paddr > OFS_SUMSQ |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
	property p_stop; psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_STOP]
		|-> ##[1:3] !feeding && !emptying; endproperty
	a_stop: assert property (p_stop) else $error("feeds still open after stop");
	property p_coarse_busy; $rose(coarse_feed) |-> cycle_busy; endproperty
	a_coarse_busy: assert property (p_coarse_busy) else $error("feed outside cycle");
	// fine feed may only run on at the result when a short result refeeds
	property p_res_quiet; $rose(result_avail) |-> !coarse_feed && (!fine_feed_output || out_of_tol) && cycle_busy;
	endproperty
	a_res_quiet: assert property (p_res_quiet) else $error("result while feeding");
	property p_oot_fail; out_of_tol |-> dose_fail; endproperty
	a_oot_fail: assert property (p_oot_fail) else $error("tolerance fault without failure");
	property p_flow_stop; $rose(flow_fail) |-> ##[0:2] !feeding; endproperty
	a_flow_stop: assert property (p_flow_stop) else $error("feeds open after flow fault");
	property p_end_quiet; $fell(cycle_busy) |-> !feeding && !emptying; endproperty
	a_end_quiet: assert property (p_end_quiet) else $error("outputs left on at cycle end");
	property p_empty_excl; emptying |-> !feeding && cycle_busy; endproperty
	a_empty_excl: assert property (p_empty_excl) else $error("emptying overlaps feeding");

	c_result: cover property ($rose(result_avail));
	c_empty: cover property ($rose(emptying));
	c_flow: cover property ($rose(flow_fail));
endmodule : fds_properties

bind fds_sequencer fds_properties #(.MS_CYCLES(MS_CYCLES)) u_props (.*);

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// sequencer bench: table of cycles, then hand tests
// ------------------------------------------------------------
module tb_top;
	import fds_pkg::*;
	typedef struct {
		logic [31:0] cfg;
		int          infl;
		int          th;
		int          tl;
		int          pct;
		logic        oot;
	} fds_row_t;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, load, shaky;
	logic start_in, suspend_in, stop_in, high_feed, coarse_feed, fine_feed_output, emptying;
	logic cycle_busy, result_avail, out_of_tol, flow_fail, dose_fail, wt_stable;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic signed [31:0] net_wt, gross_wt, load_val;
	int mismatches, total_checks, r, exp_infl;
	wire [3:0] mon = {fine_feed_output, result_avail, coarse_feed, cycle_busy};
	wire [3:0] flg = {result_avail, out_of_tol, flow_fail, dose_fail};
	logic [39:0] setup [8] = '{{OFS_TARGET, 32'hC8}, {OFS_FINE_LVL, 32'h28}, {OFS_TIME_A, 32'h0005_0001},
		{OFS_TIME_B, 32'h0001_0001}, {OFS_TIME_C, 32'h0001_0001}, {OFS_TIME_D, 32'h1},
		{OFS_FLOW_MIN, 32'h64}, {OFS_EMPTY_LVL, 32'h14}};
	// cfg, in-flight, tol+, tol-, correction %, out of tolerance
	fds_row_t rows [12] = '{'{32'h000, 0, 32'h14, 32'h14, 0, 1'b0}, '{32'h100, 0, 32'h14, 32'h14, 0, 1'b0},
		'{32'h200, 0, 32'h14, 32'h14, 0, 1'b0}, '{32'h300, 0, 32'h14, 32'h14, 0, 1'b0},
		'{32'h400, 0, 32'h14, 32'h14, 0, 1'b0}, '{32'h500, 0, 32'h14, 32'h14, 0, 1'b0},
		'{32'h600, 0, 32'h14, 32'h14, 0, 1'b0}, '{32'h700, 0, 32'h14, 32'h14, 0, 1'b0},
		'{32'h004, 0, 32'h0, 32'h14, 32'h32, 1'b1}, '{32'h204, 32'h32, 32'h14, 32'hA, 32'hA, 1'b1},
		'{32'h004, 0, 32'h14, 32'h14, 32'h64, 1'b0}, '{32'h010, 0, 32'h14, 32'h14, 0, 1'b0}};

	fds_sequencer #(.MS_CYCLES(4)) DUT (.*);
	fds_plant u_plant (.*);

	// 40 MHz clock
	always #12.5 clk = ~clk;

	task end_sim;
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// one bus transfer, held until ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16) begin
			chk("pready", 1, 0);
			end_sim;
		end
	endtask : apb

	task wait_for(input int b, input logic v, input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			@(posedge clk);
			if (mon[b] === v)
				break;
		end
		if (n == lim) begin
			chk("wait", v, mon[b]);
			end_sim;
		end
	endtask : wait_for

	task reload(input int v);
		load <= 1'b1;
		load_val <= v;
		@(posedge clk);
		load <= 1'b0;
	endtask : reload

	task run;
		apb(1, OFS_CTRL, 32'h1);
		wait_for(0, 1, 20);
		wait_for(0, 0, 4000);
	endtask : run

	task chk_res(input int c);
		apb(0, OFS_RESULT, 32'h0);
		r = rd;
		chk("result", 1, r >= c - 5 && r <= c + 15);
	endtask : chk_res

	// main sequence
	initial begin
		clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		start_in = 0; suspend_in = 0; stop_in = 0; load = 1; load_val = 0; shaky = 0;
		mismatches = 0; total_checks = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		load <= 1'b0;
		foreach (setup[i])
			apb(1, setup[i][39:32], setup[i][31:0]);
		foreach (rows[i]) begin
			apb(1, OFS_CFG, rows[i].cfg);
			apb(1, OFS_INFLIGHT, rows[i].infl);
			apb(1, OFS_TOL_HI, rows[i].th);
			apb(1, OFS_TOL_LO, rows[i].tl);
			apb(1, OFS_ADJ, rows[i].pct);
			reload(0);
			run;
			chk_res(200 - rows[i].infl);
			apb(0, OFS_STATUS, 32'h0);
			chk("status", {1'h1, rows[i].oot, 1'h0, rows[i].oot}, rd[3:0]);
			chk("pins", {1'h1, rows[i].oot, 1'h0, rows[i].oot}, flg);
			apb(0, OFS_COUNT, 32'h0);
			chk("count", i + 1, rd);
			exp_infl = rows[i].infl + (rows[i].cfg[2] ? (r - 200) * rows[i].pct * (rows[i].oot ? 3 : 1) / 100 : 0);
			apb(0, OFS_INFLIGHT, 32'h0);
			chk("inflight", exp_infl, rd);
			if (rows[i].cfg[4])
				chk("emptied", 1, gross_wt < 20);
		end
		// short result refeeds one step at a time into the low tolerance
		apb(1, OFS_CFG, 32'h8);
		apb(1, OFS_INFLIGHT, 32'hF);
		apb(1, OFS_TOL_LO, 32'hA);
		reload(0);
		run;
		chk_res(195);
		apb(0, OFS_STATUS, 32'h0);
		chk("refeed", 4'h9, rd[3:0]);
		apb(1, OFS_INFLIGHT, 32'h0);
		// stop request while high and coarse feed run
		apb(1, OFS_CFG, 32'h500);
		reload(0);
		apb(1, OFS_CTRL, 32'h1);
		wait_for(1, 1, 40);
		chk("high", 1, high_feed);
		apb(1, OFS_CTRL, 32'h2);
		wait_for(0, 0, 10);
		// suspend request without relaunch aborts
		apb(1, OFS_CTRL, 32'h1);
		wait_for(1, 1, 40);
		apb(1, OFS_CTRL, 32'h4);
		wait_for(0, 0, 10);
		// flow gain below the minimum
		apb(1, OFS_TIME_D, 32'h0001_0001);
		reload(0);
		run;
		apb(0, OFS_STATUS, 32'h0);
		chk("flow", {DIAG_FLOW, 2'h3, 1'h1}, {rd[19:16], rd[1], rd[0], flow_fail});
		apb(1, OFS_TIME_D, 32'h1);
		// start pin in negative logic, suspend and resume
		start_in <= 1'b1;
		apb(1, OFS_CFG, 32'h1002);
		repeat (20) @(posedge clk);
		apb(1, OFS_CTRL, 32'h2);
		wait_for(0, 0, 10);
		reload(0);
		start_in <= 1'b0;
		wait_for(0, 1, 40);
		wait_for(1, 1, 40);
		suspend_in <= 1'b1;
		wait_for(1, 0, 40);
		chk("frozen", 1, cycle_busy);
		start_in <= 1'b1;
		apb(1, OFS_CTRL, 32'h1);
		wait_for(1, 1, 40);
		wait_for(0, 0, 4000);
		chk_res(200);
		// start refused at the window edge, then tared start
		apb(1, OFS_CFG, 32'h1001);
		apb(1, OFS_EMPTY_MIN, 32'hA);
		apb(1, OFS_EMPTY_MAX, 32'h14);
		reload(32'h14);
		apb(1, OFS_CTRL, 32'h1);
		repeat (8) @(posedge clk);
		apb(0, OFS_STATUS, 32'h0);
		chk("refused", {DIAG_START, 1'h0, 1'h1}, {rd[19:16], rd[4], rd[0]});
		shaky <= 1'b1;
		reload(32'hF);
		run;
		apb(0, OFS_TARE, 32'h0);
		chk("tare", 32'hF, rd);
		chk_res(200);
		// second reset while the coarse feed runs
		reload(32'hF);
		apb(1, OFS_CTRL, 32'h1);
		wait_for(1, 1, 80);
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		chk("outs", 0, {mon, high_feed, emptying, out_of_tol, flow_fail, dose_fail});
		apb(0, OFS_ADJ, 32'h0);
		chk("adj", 32'h0000_0A00, rd);
		apb(0, 8'h60, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		end_sim;
	end
endmodule : tb_top
